// *** eied_pkg.sv ***
// Constants shared by the external interrupt edge detector and its noise filter
package eied_pkg;
  // Pin slots of the detector vector
  localparam int NUM_PINS = 9;
  localparam int IDX_NMI = 0;
  localparam int IDX_IRQ0 = 1;
  localparam int IDX_IRQ3 = 4;
  localparam int IDX_IRQ4 = 5;
  localparam int IDX_IRQ6 = 7;
  localparam int IDX_IRQ7 = 8;

  // Noise filter
  localparam int NF_SEL_W = 2;
  localparam int NF_DIV_W = 8;
  localparam logic [7:0] NF_BASE_DIV = 8'h02;
  localparam logic [1:0] NF_INIT_SAMPLES = 2'h3;
  localparam logic [1:0] NF_SEL_RESET = 2'h0;

  // Edge select codes, {rise, fall}
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    NF_INIT = 2'b01,
    NF_RUN = 2'b10
  } eied_nf_state_e;
endpackage : eied_pkg

// *** eied_noise_filter.sv ***
// Digital noise eliminator with selectable sampling clock for one interrupt input
`timescale 1ns/10ps
module eied_noise_filter #(
  parameter int DivW = eied_pkg::NF_DIV_W
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [eied_pkg::NF_SEL_W-1:0] sampleSel, // Sampling clock select
  input wire logic rawIn, // Synchronised pin level
  output logic filtOut // Filtered level
);
  eied_pkg::eied_nf_state_e state_r, state_nxt;
  logic [DivW-1:0] divCnt_r, divCnt_nxt;
  logic [2:0] samples_r, samples_nxt;
  logic [1:0] initCnt_r, initCnt_nxt;
  logic [eied_pkg::NF_SEL_W-1:0] selSeen_r;
  logic filt_r, filt_nxt;
  logic tick;
  logic selChange;

  assign selChange = (sampleSel != selSeen_r);
  assign tick = (divCnt_r == '0);
  assign filtOut = filt_r;

  always_comb
  begin
    divCnt_nxt = tick ? DivW'(eied_pkg::NF_BASE_DIV << sampleSel) - DivW'(1) : divCnt_r - DivW'(1);
    state_nxt = state_r;
    samples_nxt = samples_r;
    initCnt_nxt = initCnt_r;
    filt_nxt = filt_r;
    if (selChange)
    begin
      // Reinitialise: history and output are discarded, so a high pin looks like a fresh edge later
      state_nxt = eied_pkg::NF_INIT; // R7
      samples_nxt = '0;
      initCnt_nxt = '0;
      filt_nxt = 1'b0;
      divCnt_nxt = DivW'(eied_pkg::NF_BASE_DIV << sampleSel) - DivW'(1);
    end
    else if (tick)
    begin
      samples_nxt = {samples_r[1:0], rawIn};
      unique case (state_r)
        eied_pkg::NF_INIT:
        begin
          initCnt_nxt = initCnt_r + 2'h1;
          if (initCnt_r + 2'h1 == eied_pkg::NF_INIT_SAMPLES)
          begin
            // Output settles on the last init sample, so no request can appear after the window
            state_nxt = eied_pkg::NF_RUN; // R7
            filt_nxt = (samples_nxt == 3'h7); // R7
          end
        end
        eied_pkg::NF_RUN:
        begin
          if (samples_nxt == 3'h7)
          begin
            filt_nxt = 1'b1;
          end
          else if (samples_nxt == 3'h0)
          begin
            filt_nxt = 1'b0;
          end
        end
        default:
        begin
          state_nxt = eied_pkg::NF_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= eied_pkg::NF_INIT;
      divCnt_r <= '0;
      samples_r <= '0;
      initCnt_r <= '0;
      filt_r <= 1'b0;
      selSeen_r <= eied_pkg::NF_SEL_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      divCnt_r <= divCnt_nxt;
      samples_r <= samples_nxt;
      initCnt_r <= initCnt_nxt;
      filt_r <= filt_nxt;
      selSeen_r <= sampleSel;
    end
  end

  property p_reinit;
    @(posedge clk) disable iff (!reset_n)
    selChange |=> !filtOut [*3];
  endproperty
  a_reinit: assert property (p_reinit) else $error("Filter output rose during reinit"); // R7

  c_init_done: cover property (@(posedge clk) disable iff (!reset_n)
    state_r == eied_pkg::NF_INIT ##1 state_r == eied_pkg::NF_RUN);
endmodule : eied_noise_filter

// *** eied_top.sv ***
// External interrupt edge detector: per-pin edge select, request flags and DMA triggers
// How it works
// [R1] Leaving interrupt mode may raise a spurious edge.
// [R2] Software clears seventh pin selects before port mode.
// [R3] Software clears pins four-six selects before port mode.
// [R4] Unused seventh pin keeps selects at 00.
// [R5] Unused pins four-six keep selects at 00.
// [R6] Seventh pin: receiver or interrupt, never both.
// [R7] Filter reinit takes three samples after select change.
// [R8] Software waits, clears flag, then enables interrupt.
// [R9] Software waits three samples before enabling DMA.
// [R10] NMI pin is port until mode control selects it.
// [R11] NMI detects no edge after reset.
// [R12] Two select bits choose none, rise, fall, both.
// [R13] Edge sets sticky flag until clear or acknowledge.
`timescale 1ns/10ps
module eied_top #(
  parameter int NumPins = eied_pkg::NUM_PINS
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [NumPins-1:0] pinIn, // External interrupt pin levels
  input wire logic [NumPins-1:0] pinIntMode, // 1: pin in interrupt function, 0: port
  input wire logic [NumPins-1:0] riseSel, // Rising edge select per pin
  input wire logic [NumPins-1:0] fallSel, // Falling edge select per pin
  input wire logic serialRxEnable, // Receiver enable of the pin shared with the seventh input
  input wire logic [eied_pkg::NF_SEL_W-1:0] filterClkSel, // Noise filter sampling clock select
  input wire logic [NumPins-1:0] reqClear, // Software clear of request flags, pulse
  input wire logic [NumPins-1:0] reqAck, // Interrupt acknowledge, pulse
  output logic [NumPins-1:0] reqFlag, // Sticky interrupt request flags
  output logic [NumPins-1:0] dmaTrigger, // One-cycle DMA start per detected edge
  output logic rxConflict // Shared seventh pin used by receiver and detector at once
);
  logic [NumPins-1:0] syncA_r;
  logic [NumPins-1:0] syncB_r;
  logic [NumPins-1:0] detLvl;
  logic [NumPins-1:0] prevLvl_r, prevLvl_nxt;
  logic [NumPins-1:0] edgeHit;
  logic [NumPins-1:0] reqFlag_r, reqFlag_nxt;
  logic [NumPins-1:0] dma_r, dma_nxt;
  logic conflict_r, conflict_nxt;
  logic filtLvl;

  function automatic logic edge_hit(input logic rise, input logic fall, input logic prev, input logic cur);
    logic [1:0] code;
    code = {rise, fall};
    unique case (code)
      eied_pkg::EDGE_NONE: edge_hit = 1'b0;
      eied_pkg::EDGE_RISE: edge_hit = !prev && cur;
      eied_pkg::EDGE_FALL: edge_hit = prev && !cur;
      eied_pkg::EDGE_BOTH: edge_hit = prev != cur;
    endcase
  endfunction : edge_hit

  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
    end
    else
    begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
    end
  end

  eied_noise_filter #(
    .DivW(eied_pkg::NF_DIV_W)
  ) u_eied_noise_filter (
    .clk(clk),
    .reset_n(reset_n),
    .sampleSel(filterClkSel),
    .rawIn(syncB_r[eied_pkg::IDX_IRQ3]),
    .filtOut(filtLvl)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NumPins; gi++)
    begin : g_pin
      logic srcLvl;
      if (gi == eied_pkg::IDX_IRQ3)
      begin : g_filt
        assign srcLvl = filtLvl;
      end
      else
      begin : g_raw
        assign srcLvl = syncB_r[gi];
      end
      // In port mode the detector sees a low level; the drop on leaving interrupt mode
      // is seen as a falling edge, which is why selects must be cleared first.
      assign detLvl[gi] = pinIntMode[gi] ? srcLvl : 1'b0; // R1 R10
      assign edgeHit[gi] = edge_hit(riseSel[gi], fallSel[gi], prevLvl_r[gi], detLvl[gi]); // R12
    end
  endgenerate

  always_comb
  begin
    prevLvl_nxt = detLvl;
    // Set beats clear when both land in the same cycle
    reqFlag_nxt = (reqFlag_r & ~(reqClear | reqAck)) | edgeHit; // R13
    dma_nxt = edgeHit;
    // Flags a software slip on the shared receive pin; detection itself is not blocked
    conflict_nxt = serialRxEnable && pinIntMode[eied_pkg::IDX_IRQ7]
      && (riseSel[eied_pkg::IDX_IRQ7] || fallSel[eied_pkg::IDX_IRQ7]); // R6
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Level history starts low and selects are software owned, so no edge at reset
      prevLvl_r <= '0; // R11
      reqFlag_r <= '0;
      dma_r <= '0;
      conflict_r <= 1'b0;
    end
    else
    begin
      prevLvl_r <= prevLvl_nxt;
      reqFlag_r <= reqFlag_nxt;
      dma_r <= dma_nxt;
      conflict_r <= conflict_nxt;
    end
  end

  assign reqFlag = reqFlag_r;
  assign dmaTrigger = dma_r;
  assign rxConflict = conflict_r;

  property p_flag_set;
    @(posedge clk) disable iff (!reset_n)
    (|edgeHit) |=> ((reqFlag & $past(edgeHit)) == $past(edgeHit));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Detected edge did not set its flag"); // R13

  property p_flag_hold;
    @(posedge clk) disable iff (!reset_n)
    ##1 (($past(reqFlag) & ~$past(reqClear) & ~$past(reqAck) & ~reqFlag) == '0);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag dropped without clear or acknowledge"); // R13

  property p_sel_none;
    @(posedge clk) disable iff (!reset_n)
    (!riseSel[eied_pkg::IDX_IRQ0] && !fallSel[eied_pkg::IDX_IRQ0] && !reqFlag[eied_pkg::IDX_IRQ0]
      && !reqClear[eied_pkg::IDX_IRQ0]) |=> !reqFlag[eied_pkg::IDX_IRQ0];
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("Flag set with edge detection off"); // R12

  property p_rise_only;
    @(posedge clk) disable iff (!reset_n)
    (riseSel[eied_pkg::IDX_IRQ4] && !fallSel[eied_pkg::IDX_IRQ4]
      && prevLvl_r[eied_pkg::IDX_IRQ4] && !detLvl[eied_pkg::IDX_IRQ4])
      |=> !dmaTrigger[eied_pkg::IDX_IRQ4];
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("Falling edge hit with rise-only select"); // R12

  property p_spurious;
    @(posedge clk) disable iff (!reset_n)
    ($past(pinIntMode[eied_pkg::IDX_IRQ4]) && !pinIntMode[eied_pkg::IDX_IRQ4]
      && prevLvl_r[eied_pkg::IDX_IRQ4] && fallSel[eied_pkg::IDX_IRQ4])
      |=> dmaTrigger[eied_pkg::IDX_IRQ4] && reqFlag[eied_pkg::IDX_IRQ4];
  endproperty
  a_spurious: assert property (p_spurious) else $error("Port switch edge not registered"); // R1

  property p_port_mode;
    @(posedge clk) disable iff (!reset_n)
    (!pinIntMode[eied_pkg::IDX_NMI] && !$past(pinIntMode[eied_pkg::IDX_NMI]))
      |=> !dmaTrigger[eied_pkg::IDX_NMI];
  endproperty
  a_port_mode: assert property (p_port_mode) else $error("NMI edge seen while in port mode"); // R10

  property p_nmi_reset;
    @(posedge clk)
    !reset_n ##1 reset_n |-> !reqFlag[eied_pkg::IDX_NMI] ##1 !dmaTrigger[eied_pkg::IDX_NMI];
  endproperty
  a_nmi_reset: assert property (p_nmi_reset) else $error("NMI edge right after reset"); // R11

  property p_clear;
    @(posedge clk) disable iff (!reset_n)
    (|(reqClear & ~edgeHit)) |=> ((reqFlag & $past(reqClear) & ~$past(edgeHit)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("Flag survived a clear with no new edge"); // R13

  property p_ack;
    @(posedge clk) disable iff (!reset_n)
    (|(reqAck & ~edgeHit)) |=> ((reqFlag & $past(reqAck) & ~$past(edgeHit)) == '0);
  endproperty
  a_ack: assert property (p_ack) else $error("Flag survived an acknowledge with no new edge"); // R13

  property p_dma_flag;
    @(posedge clk) disable iff (!reset_n)
    (dmaTrigger & ~reqFlag) == '0;
  endproperty
  a_dma_flag: assert property (p_dma_flag) else $error("DMA start without request flag"); // R13

  property p_none_all;
    @(posedge clk) disable iff (!reset_n)
    ##1 ((reqFlag & ~$past(riseSel) & ~$past(fallSel) & ~$past(reqFlag)) == '0);
  endproperty
  a_none_all: assert property (p_none_all) else $error("Flag set on a pin with detection off"); // R12

  property p_conflict_set;
    @(posedge clk) disable iff (!reset_n)
    (serialRxEnable && pinIntMode[eied_pkg::IDX_IRQ7]
      && (riseSel[eied_pkg::IDX_IRQ7] || fallSel[eied_pkg::IDX_IRQ7])) |=> rxConflict;
  endproperty
  a_conflict_set: assert property (p_conflict_set) else $error("Shared pin conflict not flagged"); // R6

  property p_conflict_clear;
    @(posedge clk) disable iff (!reset_n)
    !serialRxEnable |=> !rxConflict;
  endproperty
  a_conflict_clear: assert property (p_conflict_clear) else $error("Conflict flagged with receiver off"); // R6

  c_nmi_flag: cover property (@(posedge clk) disable iff (!reset_n) $rose(reqFlag[eied_pkg::IDX_NMI]));
  c_spurious: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(pinIntMode[eied_pkg::IDX_IRQ4]) ##1 dmaTrigger[eied_pkg::IDX_IRQ4]);
  c_filt_edge: cover property (@(posedge clk) disable iff (!reset_n) $rose(reqFlag[eied_pkg::IDX_IRQ3]));
  c_clear_race: cover property (@(posedge clk) disable iff (!reset_n)
    (edgeHit[eied_pkg::IDX_IRQ0] && reqClear[eied_pkg::IDX_IRQ0]));
endmodule : eied_top

// *** eied_src_model.sv ***
// Pin source and software model driving the detector inputs
`timescale 1ns/10ps
module eied_src_model (
  input wire logic clk, // System clock
  output logic [8:0] pinIn, // Pin levels
  output logic [8:0] pinIntMode, // 1: interrupt function
  output logic [8:0] riseSel, // Rising selects
  output logic [8:0] fallSel, // Falling selects
  output logic serialRxEnable, // Receiver enable
  output logic [1:0] filterClkSel // Filter sampling select
);
  initial
  begin
    pinIn = '0;
    pinIntMode = '0;
    riseSel = '0;
    fallSel = '0;
    serialRxEnable = 1'b0;
    filterClkSel = eied_pkg::NF_SEL_RESET;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic setPin(input int i, input logic v);
    step();
    pinIn[i] = v;
  endtask : setPin

  task automatic setSel(input int i, input logic [1:0] code);
    step();
    {riseSel[i], fallSel[i]} = code;
  endtask : setSel

  task automatic setMode(input int i, input logic v);
    step();
    pinIntMode[i] = v;
  endtask : setMode

  // Selects go first so that leaving the function shows no edge
  task automatic toPort(input int i);
    setSel(i, eied_pkg::EDGE_NONE);
    setMode(i, 1'b0);
  endtask : toPort

  task automatic setRx(input logic v);
    step();
    serialRxEnable = v;
  endtask : setRx

  task automatic useRx();
    toPort(eied_pkg::IDX_IRQ7);
    setRx(1'b1);
  endtask : useRx

  // Settling waits the three-sample reinit, with a little margin for tick phase
  task automatic setFilter(input logic [1:0] sel, input bit settle);
    step();
    filterClkSel = sel;
    if (settle)
      repeat (3 * (2 << sel) + 4) step();
  endtask : setFilter
endmodule : eied_src_model

// *** eied_top_bench.sv ***
// Self-checking bench for the external interrupt edge detector
`timescale 1ns/10ps
module eied_top_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] reqClear = '0;
  logic [8:0] reqAck = '0;
  logic [8:0] pinIn, pinIntMode, riseSel, fallSel, reqFlag, dmaTrigger;
  logic serialRxEnable, rxConflict;
  logic [1:0] filterClkSel;
  int nErrors = 0;
  int testsRun = 0;
  int pulses = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  eied_src_model u_eied_src_model (.clk(clk), .pinIn(pinIn), .pinIntMode(pinIntMode), .riseSel(riseSel),
    .fallSel(fallSel), .serialRxEnable(serialRxEnable), .filterClkSel(filterClkSel));

  eied_top u_eied_top (.clk(clk), .reset_n(reset_n), .pinIn(pinIn), .pinIntMode(pinIntMode),
    .riseSel(riseSel), .fallSel(fallSel), .serialRxEnable(serialRxEnable), .filterClkSel(filterClkSel),
    .reqClear(reqClear), .reqAck(reqAck), .reqFlag(reqFlag), .dmaTrigger(dmaTrigger), .rxConflict(rxConflict));

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // A pulse held two cycles counts twice, so width errors show
  always @(posedge clk)
  begin
    pulses <= pulses + $countones(dmaTrigger);
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      nErrors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitCyc

  task automatic clearReq(input int i, input bit ack);
    @(posedge clk);
    #1;
    if (ack)
      reqAck[i] = 1'b1;
    else
      reqClear[i] = 1'b1;
    waitCyc(1);
    reqAck = '0;
    reqClear = '0;
  endtask : clearReq

  initial
  begin
    int p0;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    waitCyc(2);
    check("flags after reset", 0, reqFlag);
    u_eied_src_model.setSel(0, eied_pkg::EDGE_RISE);
    u_eied_src_model.setPin(0, 1'b1);
    waitCyc(6);
    check("nmi in port mode", 0, reqFlag[0]);
    u_eied_src_model.setMode(0, 1'b1);
    waitCyc(6);
    check("nmi selected", 1, reqFlag[0]);
    clearReq(0, 1'b0);
    $display("Test nmi done");
    for (int i = 1; i < 9; i++)
    begin
      if (i == eied_pkg::IDX_IRQ3)
        continue;
      u_eied_src_model.setMode(i, 1'b1);
      for (int c = 0; c < 4; c++)
      begin
        u_eied_src_model.setSel(i, 2'(c));
        p0 = pulses;
        u_eied_src_model.setPin(i, 1'b1);
        waitCyc(6);
        u_eied_src_model.setPin(i, 1'b0);
        waitCyc(6);
        check("edge pulses", c[1] + c[0], pulses - p0);
        check("sticky flag", c[1] | c[0], reqFlag[i]);
        clearReq(i, c[0]);
        check("flag cleared", 0, reqFlag[i]);
      end
    end
    $display("Test edge select done");
    u_eied_src_model.setSel(5, eied_pkg::EDGE_FALL);
    u_eied_src_model.setPin(5, 1'b1);
    waitCyc(6);
    check("rise on fall select", 0, reqFlag[5]);
    u_eied_src_model.setMode(5, 1'b0);
    waitCyc(6);
    check("spurious on port switch", 1, reqFlag[5]);
    clearReq(5, 1'b0);
    u_eied_src_model.setMode(5, 1'b1);
    u_eied_src_model.toPort(5);
    waitCyc(6);
    check("clean port switch", 0, reqFlag[5]);
    u_eied_src_model.setSel(8, eied_pkg::EDGE_RISE);
    u_eied_src_model.setRx(1'b1);
    waitCyc(3);
    check("shared pin conflict", 1, rxConflict);
    u_eied_src_model.useRx();
    waitCyc(3);
    check("receiver only", 0, rxConflict);
    $display("Test port switch done");
    u_eied_src_model.setMode(4, 1'b1);
    u_eied_src_model.setSel(4, eied_pkg::EDGE_RISE);
    u_eied_src_model.setPin(4, 1'b1);
    waitCyc(40);
    check("filtered edge", 1, reqFlag[4]);
    clearReq(4, 1'b0);
    u_eied_src_model.setFilter(2'h1, 1'b0);
    waitCyc(60);
    check("reinit request", 1, reqFlag[4]);
    clearReq(4, 1'b0);
    u_eied_src_model.setFilter(2'h2, 1'b1);
    clearReq(4, 1'b0);
    p0 = pulses;
    waitCyc(40);
    check("settled filter", 0, reqFlag[4]);
    check("no late dma start", 0, pulses - p0);
    $display("Test filter done");
    summarize();
  end
endmodule : eied_top_bench
